// ---- hdl/lfs_defines.svh ----
// constants of the led driver fault status register bank
`ifndef LFS_DEFINES_SVH
`define LFS_DEFINES_SVH

// ****************************************************************
// register indices and byte addresses
// ****************************************************************
`define LFS_ADDR_W 12
`define LFS_IRQ_EN_IDX 8'h0c
`define LFS_BOOST_IDX 8'h10
`define LFS_STRING_IDX 8'h12
`define LFS_IRQ_EN_ADDR {2'b00, `LFS_IRQ_EN_IDX, 2'b00}
`define LFS_BOOST_ADDR {2'b00, `LFS_BOOST_IDX, 2'b00}
`define LFS_STRING_ADDR {2'b00, `LFS_STRING_IDX, 2'b00}

// ****************************************************************
// field layout
// ****************************************************************
`define LFS_REG_W 16
`define LFS_BOOST_PAIRS 8
`define LFS_TIMEOUT_FLAG_BIT 14
`define LFS_TIMEOUT_ACK_BIT 13
`define LFS_BADCFG_FLAG_BIT 12
`define LFS_BADCFG_ACK_BIT 11
`define LFS_SUMMARY_FLAG_BIT 10
`define LFS_SUMMARY_ACK_BIT 9
`define LFS_GND_SHORT_BIT 8
`define LFS_INT_SHORT_BIT 7
`define LFS_OPEN_BIT 6
`define LFS_CHAN_LO_BIT 0
`define LFS_CHANNELS 4
`define LFS_EN_FIELDS 4
`define LFS_EN_SUMMARY 0
`define LFS_EN_BADCFG 1
`define LFS_EN_TIMEOUT 2
`define LFS_EN_GLOBAL 3

// ****************************************************************
// enable field codes and reset values
// ****************************************************************
`define LFS_EN_WR_OFF 2'h1
`define LFS_EN_WR_ON 2'h3
`define LFS_EN_RD_OFF 2'h0
`define LFS_EN_RD_ON 2'h2
`define LFS_EN_RESET 1'b1
`define LFS_FLAG_RESET 1'b0
`define LFS_RDATA_RESET 32'h0000_0000

`endif

// ---- hdl/lfs_fault_regs.sv ----
// led driver fault status registers behind an apb slave
//
// What this block does
// (RULE1) clear needs status and clear bits written together
// (RULE2) thermal trip flag bit 15, ack 14
// (RULE3) current resistor short flag bit 13, ack 12
// (RULE4) string resistor missing bit 11, ack 10
// (RULE5) mode resistor missing bit 9, ack 8
// (RULE6) freq resistor missing bit 7, ack 6
// (RULE7) boost overcurrent bit 5, ack 4
// (RULE8) boost overvolt high bit 3, ack 2
// (RULE9) boost overvolt low bit 1, ack 0
// (RULE10) serial bus timeout bit 14, ack 13
// (RULE11) bad string config bit 12, ack 11
// (RULE12) summary string fault bit 10, ack 9
// (RULE13) read-only ground short detail at bit 8
// (RULE14) internal short detail bit 7, cleared with summary
// (RULE15) open detail bit 6, cleared with summary
// (RULE16) host writes zero to reserved bits 5,4
// (RULE17) channel faults bits 3..0, channel four top
// (RULE18) offsets 10h and 12h, all fields reset zero; channel bits 3..0 are not reset, they follow the detectors
// (RULE19) enable fields read 0h/2h, written 1h/3h
// (RULE20) flags stay until cleared; interrupt while enabled
// (RULE21) half writes or re-detection leave flag set
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "lfs_defines.svh"

module lfs_fault_regs (
  input wire logic SYS_CLK,                     // 10 mhz clock
  input wire logic RST_N,                       // async reset, active low
  input wire lfs_pkg::lfs_apb_req_s APB_REQ,    // apb request from host
  output lfs_pkg::lfs_apb_rsp_s APB_RSP,        // apb answer
  input wire logic [7:0] BOOST_DET,             // boost detectors, bit i -> pair i
  input wire lfs_pkg::lfs_string_det_s STR_DET, // string detectors
  output logic FAULT_IRQ_N                      // interrupt pin, active low
);
  import lfs_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  lfs_bank_s state_reg;
  lfs_bank_s state_next;

  logic [7:0] boost_flag;
  logic [7:0] boost_clear;
  logic [7:0] boost_status_wr;
  logic [7:0] boost_ack_wr;
  logic timeout_flag;
  logic badcfg_flag;
  logic summary_flag;
  logic gnd_flag;
  logic short_flag;
  logic open_flag;
  logic timeout_clear;
  logic badcfg_clear;
  logic summary_clear;
  logic summary_det;

  // ****************************************************************
  // apb decode
  // ****************************************************************
  logic setup_phase;
  logic access_phase;
  logic wr_en;
  logic hit_boost;
  logic hit_string;
  logic hit_irq_en;
  logic hit_any;
  logic [15:0] wd;
  logic wr_boost;
  logic wr_string;
  logic wr_irq_en;

  assign setup_phase = APB_REQ.psel & ~APB_REQ.penable;
  assign access_phase = APB_REQ.psel & APB_REQ.penable;
  assign hit_boost = (APB_REQ.paddr == `LFS_BOOST_ADDR);  // [RULE18]
  assign hit_string = (APB_REQ.paddr == `LFS_STRING_ADDR);  // [RULE18]
  assign hit_irq_en = (APB_REQ.paddr == `LFS_IRQ_EN_ADDR);
  assign hit_any = hit_boost | hit_string | hit_irq_en;
  assign wr_en = access_phase & APB_REQ.pwrite & hit_any;
  // one write strobe per register; a miss writes nothing
  assign wr_boost = wr_en & hit_boost;
  assign wr_string = wr_en & hit_string;
  assign wr_irq_en = wr_en & hit_irq_en;

  // a byte lane left out by pstrb cannot form a status/clear pair
  assign wd = APB_REQ.pwdata[15:0] & {{8{APB_REQ.pstrb[1]}}, {8{APB_REQ.pstrb[0]}}};

  // ****************************************************************
  // boost flags
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < `LFS_BOOST_PAIRS; gi = gi + 1) begin : g_boost
      // flag at odd bit, its ack just below it
      assign boost_status_wr[gi] = wd[2*gi+1];  // [RULE2] [RULE3] [RULE4] [RULE5]
      assign boost_ack_wr[gi] = wd[2*gi];  // [RULE6] [RULE7] [RULE8] [RULE9]
      assign boost_clear[gi] = wr_boost & boost_status_wr[gi] & boost_ack_wr[gi];  // [RULE1]
      lfs_flag_cell u_cell (
        .sys_clk(SYS_CLK),
        .rst_n(RST_N),
        .detect(BOOST_DET[gi]),
        .clear(boost_clear[gi]),
        .flag(boost_flag[gi])
      );
    end
  endgenerate

  // ****************************************************************
  // string flags
  // ****************************************************************
  assign timeout_clear = wr_string & wd[`LFS_TIMEOUT_FLAG_BIT]
                         & wd[`LFS_TIMEOUT_ACK_BIT];  // [RULE1] [RULE10]
  assign badcfg_clear = wr_string & wd[`LFS_BADCFG_FLAG_BIT]
                        & wd[`LFS_BADCFG_ACK_BIT];  // [RULE1] [RULE11]
  assign summary_clear = wr_string & wd[`LFS_SUMMARY_FLAG_BIT]
                         & wd[`LFS_SUMMARY_ACK_BIT];  // [RULE1] [RULE12]
  assign summary_det = STR_DET.open | STR_DET.internal_short | STR_DET.ground_short;  // [RULE12]

  lfs_flag_cell u_timeout (
    .sys_clk(SYS_CLK),
    .rst_n(RST_N),
    .detect(STR_DET.bus_timeout),
    .clear(timeout_clear),
    .flag(timeout_flag)
  );

  lfs_flag_cell u_badcfg (
    .sys_clk(SYS_CLK),
    .rst_n(RST_N),
    .detect(STR_DET.bad_string_cfg),
    .clear(badcfg_clear),
    .flag(badcfg_flag)
  );

  lfs_flag_cell u_summary (
    .sys_clk(SYS_CLK),
    .rst_n(RST_N),
    .detect(summary_det),
    .clear(summary_clear),
    .flag(summary_flag)
  );

  // details have no ack of their own; they ride on the summary clear
  lfs_flag_cell u_gnd (
    .sys_clk(SYS_CLK),
    .rst_n(RST_N),
    .detect(STR_DET.ground_short),
    .clear(summary_clear),  // [RULE13]
    .flag(gnd_flag)
  );

  lfs_flag_cell u_short (
    .sys_clk(SYS_CLK),
    .rst_n(RST_N),
    .detect(STR_DET.internal_short),
    .clear(summary_clear),  // [RULE14]
    .flag(short_flag)
  );

  lfs_flag_cell u_open (
    .sys_clk(SYS_CLK),
    .rst_n(RST_N),
    .detect(STR_DET.open),
    .clear(summary_clear),  // [RULE15]
    .flag(open_flag)
  );

  // ****************************************************************
  // read images
  // ****************************************************************
  logic [15:0] boost_image;
  logic [15:0] string_image;
  logic [15:0] irq_en_image;

  always_comb begin
    boost_image = 16'h0000;
    for (int i = 0; i < `LFS_BOOST_PAIRS; i++) begin
      // ack bits hold no state and read back as zero
      boost_image[2*i+1] = boost_flag[i];  // [RULE2] [RULE9]
    end
  end

  always_comb begin
    string_image = 16'h0000;
    string_image[`LFS_TIMEOUT_FLAG_BIT] = timeout_flag;  // [RULE10]
    string_image[`LFS_BADCFG_FLAG_BIT] = badcfg_flag;  // [RULE11]
    string_image[`LFS_SUMMARY_FLAG_BIT] = summary_flag;  // [RULE12]
    string_image[`LFS_GND_SHORT_BIT] = gnd_flag;  // [RULE13]
    string_image[`LFS_INT_SHORT_BIT] = short_flag;  // [RULE14]
    string_image[`LFS_OPEN_BIT] = open_flag;  // [RULE15]
    // reserved 5:4 read zero; host writes to them are dropped
    string_image[`LFS_CHAN_LO_BIT +: `LFS_CHANNELS] = STR_DET.channel;  // [RULE17]
  end

  always_comb begin
    irq_en_image = 16'h0000;
    for (int i = 0; i < `LFS_EN_FIELDS; i++) begin
      irq_en_image[2*i +: 2] = state_reg.irq_en[i] ? `LFS_EN_RD_ON : `LFS_EN_RD_OFF;  // [RULE19]
    end
  end

  // ****************************************************************
  // enable field writes
  // ****************************************************************
  logic [3:0] en_set;
  logic [3:0] en_clr;

  // only the two documented codes act; 0h and 2h leave a field alone
  always_comb begin
    en_set = 4'h0;
    en_clr = 4'h0;
    for (int i = 0; i < `LFS_EN_FIELDS; i++) begin
      en_set[i] = wr_irq_en & (wd[2*i +: 2] == `LFS_EN_WR_ON);  // [RULE19]
      en_clr[i] = wr_irq_en & (wd[2*i +: 2] == `LFS_EN_WR_OFF);  // [RULE19]
    end
  end

  // ****************************************************************
  // read select
  // ****************************************************************
  logic [2:0] rd_sel;
  logic [15:0] rd_image;

  assign rd_sel = {hit_irq_en, hit_string, hit_boost};

  // addresses are distinct, so at most one hit is high
  always_comb begin
    rd_image = 16'h0000;
    unique case (rd_sel)
      3'b000: begin
        rd_image = 16'h0000;
      end
      3'b001: begin
        rd_image = boost_image;
      end
      3'b010: begin
        rd_image = string_image;
      end
      3'b100: begin
        rd_image = irq_en_image;
      end
    endcase
  end

  // ****************************************************************
  // interrupt sources
  // ****************************************************************
  logic boost_src;
  logic timeout_src;
  logic badcfg_src;
  logic summary_src;
  logic any_fault;

  // boost flags have no field of their own; only the global enable gates them
  assign boost_src = |boost_flag;  // [RULE20]
  assign timeout_src = timeout_flag & state_reg.irq_en[`LFS_EN_TIMEOUT];  // [RULE20]
  assign badcfg_src = badcfg_flag & state_reg.irq_en[`LFS_EN_BADCFG];  // [RULE20]
  assign summary_src = summary_flag & state_reg.irq_en[`LFS_EN_SUMMARY];  // [RULE20]
  // the pin is registered so a decode glitch never reaches it
  assign any_fault = boost_src | timeout_src | badcfg_src | summary_src;

  // ****************************************************************
  // next state
  // ****************************************************************

  always_comb begin
    state_next = state_reg;
    state_next.irq_en = (state_reg.irq_en | en_set) & ~en_clr;  // [RULE19]
    // read data is captured in setup so it stands during access
    if (setup_phase) begin
      state_next.rdata = {16'h0000, rd_image};
    end
    state_next.irq = state_reg.irq_en[`LFS_EN_GLOBAL] & any_fault;  // [RULE20]
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_reg.irq_en <= {`LFS_EN_FIELDS{`LFS_EN_RESET}};
      state_reg.rdata <= `LFS_RDATA_RESET;
      state_reg.irq <= `LFS_FLAG_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // zero wait states: every access completes in its first access cycle
  // one assignment drives the whole answer struct
  assign APB_RSP = '{
    pready: 1'b1,
    prdata: state_reg.rdata,
    pslverr: access_phase & ~hit_any
  };
  assign FAULT_IRQ_N = ~state_reg.irq;

endmodule // lfs_fault_regs

`default_nettype wire

// ---- hdl/lfs_flag_cell.sv ----
// one latched fault flag with its paired clear
`timescale 1ns/1ns
`default_nettype none
`include "lfs_defines.svh"

module lfs_flag_cell (
  input wire logic sys_clk,  // bank clock
  input wire logic rst_n,    // async reset, active low
  input wire logic detect,   // fault seen this cycle
  input wire logic clear,    // paired clear strobe
  output logic flag          // latched fault
);
  import lfs_pkg::*;

  lfs_cell_s state_reg;
  lfs_cell_s state_next;

  // a fresh detection beats the clear so no event is lost
  always_comb begin
    state_next = state_reg;
    state_next.flag = detect | (state_reg.flag & ~clear);  // [RULE20] [RULE21]
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg.flag <= `LFS_FLAG_RESET;  // [RULE18]
    end else begin
      state_reg <= state_next;
    end
  end

  assign flag = state_reg.flag;

endmodule // lfs_flag_cell

`default_nettype wire

// ---- hdl/lfs_pkg.sv ----
// types shared by the fault status register bank
package lfs_pkg;

  // ****************************************************************
  // apb carriers
  // ****************************************************************
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } lfs_apb_req_s;

  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } lfs_apb_rsp_s;

  // ****************************************************************
  // fault detector inputs of the string side
  // ****************************************************************
  typedef struct packed {
    logic bus_timeout;
    logic bad_string_cfg;
    logic ground_short;
    logic internal_short;
    logic open;
    logic [3:0] channel;
  } lfs_string_det_s;

  // ****************************************************************
  // module state
  // ****************************************************************
  typedef struct packed {
    logic flag;
  } lfs_cell_s;

  typedef struct packed {
    logic [3:0] irq_en;
    logic [31:0] rdata;
    logic irq;
  } lfs_bank_s;

endpackage

// ---- verif/lfs_fault_regs_assertions.sv ----
// port checker of the fault status bank
`timescale 1ns/1ns
`default_nettype none
`include "lfs_defines.svh"
module lfs_chk (
  input wire logic SYS_CLK, // clock
  input wire logic RST_N, // reset, active low
  input wire lfs_pkg::lfs_apb_req_s APB_REQ, // apb request
  input wire lfs_pkg::lfs_apb_rsp_s APB_RSP, // apb answer
  input wire logic [7:0] BOOST_DET, // boost detectors
  input wire lfs_pkg::lfs_string_det_s STR_DET, // string detectors
  input wire logic FAULT_IRQ_N // interrupt pin
);
  import lfs_pkg::*;
  logic acc;
  logic wr;
  logic rb;
  logic rs;
  logic ok;
  assign acc = APB_REQ.psel & APB_REQ.penable;
  assign wr = acc & APB_REQ.pwrite;
  assign rb = acc & ~APB_REQ.pwrite & (APB_REQ.paddr == `LFS_BOOST_ADDR);
  assign rs = acc & ~APB_REQ.pwrite & (APB_REQ.paddr == `LFS_STRING_ADDR);
  assign ok = APB_REQ.paddr inside {`LFS_IRQ_EN_ADDR, `LFS_BOOST_ADDR, `LFS_STRING_ADDR};
  default clocking @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);
  // ****************
  // port relations
  // ****************
  ready_high_a: assert property (APB_RSP.pready) else $error("pready low");
  unmapped_err_a: assert property (acc && !ok |-> APB_RSP.pslverr)
    else $error("no slverr");
  mapped_ok_a: assert property (acc && ok |-> !APB_RSP.pslverr)
    else $error("bad slverr");
  upper_zero_a: assert property (acc && !APB_REQ.pwrite |-> APB_RSP.prdata[31:16] == 16'h0000)
    else $error("upper bits set");
  boost_ack_a: assert property (rb |-> (APB_RSP.prdata[15:0] & 16'h5555) == 16'h0000)
    else $error("boost ack reads one");
  string_rsv_a: assert property (rs |-> (APB_RSP.prdata[15:0] & 16'haa30) == 16'h0000)
    else $error("string reserved reads one");
  chan_live_a: assert property (rs |-> APB_RSP.prdata[3:0] == $past(STR_DET.channel))
    else $error("channel bits wrong");
  // the pin only lets go after a write, never on its own
  irq_rise_a: assert property ($rose(FAULT_IRQ_N) |-> $past(wr) || $past(wr, 2))
    else $error("irq released without write");
  irq_fall_a: assert property ($fell(FAULT_IRQ_N) |->
    $past(|{BOOST_DET, STR_DET[8:4]}, 2) || $past(wr) || $past(wr, 2))
    else $error("irq without cause");
  cover property (wr && APB_REQ.paddr == `LFS_BOOST_ADDR);
  cover property ($fell(FAULT_IRQ_N));
  cover property (acc && !ok);
endmodule // lfs_chk
`default_nettype wire

// ---- verif/lfs_host_model.sv ----
// apb host model that drives the bank
`timescale 1ns/1ns
`default_nettype none
module lfs_host_model (
  input wire logic sys_clk, // bank clock
  output lfs_pkg::lfs_apb_req_s req, // request to the bank
  input wire lfs_pkg::lfs_apb_rsp_s rsp // answer of the bank
);
  import lfs_pkg::*;
  initial req = '0;
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge sys_clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d, pstrb: s};
    @(posedge sys_clk);
    req.penable <= 1'b1;
    @(posedge sys_clk);
    while (rsp.pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge sys_clk);
    end
    r = rsp.prdata;
    e = rsp.pslverr;
    // released lines show garbage so stale values cannot pass
    req <= '{psel: 1'b0, penable: 1'b0, pwrite: ~w, paddr: ~a, pwdata: ~d, pstrb: ~s};
    if (n == 20) begin
      tb_top.n_fail++;
      tb_top.results();
    end
  endtask
endmodule // lfs_host_model
`default_nettype wire

// ---- verif/tb_top.sv ----
// self-checking bench of the fault status bank
`timescale 1ns/1ns
`default_nettype none
`include "lfs_defines.svh"
module tb_top;
  import lfs_pkg::*;
  localparam logic [11:0] BA = `LFS_BOOST_ADDR;
  localparam logic [11:0] SA = `LFS_STRING_ADDR;
  localparam logic [11:0] EA = `LFS_IRQ_EN_ADDR;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  lfs_apb_req_s apb_req;
  lfs_apb_rsp_s apb_rsp;
  logic [7:0] boost_det = 8'h00;
  lfs_string_det_s str_det = '0;
  logic fault_irq_n;
  int n_fail = 0;
  int check_count = 0;
  always #50 sys_clk = ~sys_clk;
  lfs_fault_regs u_dut (.SYS_CLK(sys_clk), .RST_N(rst_n), .APB_REQ(apb_req), .APB_RSP(apb_rsp),
    .BOOST_DET(boost_det), .STR_DET(str_det), .FAULT_IRQ_N(fault_irq_n));
  lfs_host_model u_host (.sys_clk(sys_clk), .req(apb_req), .rsp(apb_rsp));
  // ****************
  // helpers
  // ****************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    logic [31:0] r;
    logic e;
    u_host.xfer(1'b1, a, {16'h0000, d}, 4'hf, r, e);
  endtask
  task automatic rd(input logic [11:0] a, input logic [15:0] x);
    logic [31:0] r;
    logic e;
    u_host.xfer(1'b0, a, 32'h0, 4'hf, r, e);
    check(r, {16'h0000, x});
  endtask
  task automatic pulse(input logic [7:0] b, input lfs_string_det_s s);
    @(posedge sys_clk);
    boost_det <= b;
    str_det <= s;
    @(posedge sys_clk);
    boost_det <= 8'h00;
    str_det <= '{channel: s.channel, default: 1'b0};
    repeat (2) @(posedge sys_clk);
  endtask
  // ****************
  // main sequence
  // ****************
  initial begin
    logic [15:0] f;
    logic [31:0] r;
    logic e;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(BA, 16'h0000);
    rd(SA, 16'h0000);
    rd(EA, 16'h00aa);
    for (int i = 0; i < 8; i++) begin
      f = 16'h0001 << (2 * i + 1);
      pulse(8'h01 << i, '0);
      check({31'h0, fault_irq_n}, 32'h0);
      wr(BA, f);
      wr(BA, f >> 1);
      rd(BA, f);
      wr(BA, f | (f >> 1));
      rd(BA, 16'h0000);
      check({31'h0, fault_irq_n}, 32'h1);
    end
    // detector still high during the clear: the flag must survive
    @(posedge sys_clk);
    boost_det <= 8'h80;
    wr(BA, 16'hc000);
    boost_det <= 8'h00;
    rd(BA, 16'h8000);
    wr(BA, 16'hc000);
    pulse(8'h00, 9'h1f9);
    check({31'h0, fault_irq_n}, 32'h0);
    rd(SA, 16'h55c9);
    wr(SA, 16'h0400);
    rd(SA, 16'h55c9);
    wr(SA, 16'h0600);
    rd(SA, 16'h5009);
    wr(SA, 16'h6000);
    rd(SA, 16'h1009);
    wr(SA, 16'h1800);
    str_det.channel <= 4'h6;
    rd(SA, 16'h0006);
    check({31'h0, fault_irq_n}, 32'h1);
    wr(EA, 16'h0055);
    rd(EA, 16'h0000);
    wr(EA, 16'h00aa);
    rd(EA, 16'h0000);
    pulse(8'h00, 9'h106);
    check({31'h0, fault_irq_n}, 32'h1);
    wr(EA, 16'h00ff);
    rd(EA, 16'h00aa);
    check({31'h0, fault_irq_n}, 32'h0);
    u_host.xfer(1'b1, 12'h044, 32'h0000_ffff, 4'hf, r, e);
    check({31'h0, e}, 32'h1);
    u_host.xfer(1'b0, 12'h044, 32'h0, 4'hf, r, e);
    check(r, 32'h0);
    // mid-run reset with flags set
    pulse(8'hff, 9'h006);
    rst_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(BA, 16'h0000);
    rd(SA, 16'h0006);
    rd(EA, 16'h00aa);
    results();
  end
endmodule // tb_top
bind lfs_fault_regs lfs_chk u_chk (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .APB_REQ(APB_REQ),
  .APB_RSP(APB_RSP), .BOOST_DET(BOOST_DET), .STR_DET(STR_DET), .FAULT_IRQ_N(FAULT_IRQ_N));
`default_nettype wire
